// ---- hw/cbdf_pkg.sv ----
package cbdf_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STORE_MASK = 8'h04;
  localparam logic [7:0] REG_LENGTH = 8'h08;
  localparam logic [7:0] REG_SERIAL = 8'h0C;
  localparam logic [7:0] REG_DELIM = 8'h10;
  localparam logic [7:0] REG_CMD = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  // Field positions.
  localparam int CTRL_FAST_BIT = 0;
  localparam int CTRL_DUAL_BIT = 1;
  localparam int SER_OPT_LSB = 8;
  localparam int OPT_DATA8_BIT = 0;
  localparam int CMD_KIND_LSB = 24;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_DONE_BIT = 2;
  localparam int MASK_W = 22;
  localparam int DIGITS = 10;
  // Reset values.
  localparam logic [7:0] DELIM_RST = 8'h2C;
  localparam logic [3:0] SER_BAUD_RST = 4'hB;
  localparam logic [4:0] SER_OPT_RST = 5'h01;
  localparam logic [16:0] LEN_RST = 17'h00001;
  // Curve numbering and limits.
  localparam logic [4:0] FREQ_LO_CURVE = 5'h0F;
  localparam logic [4:0] FREQ_HI_CURVE = 5'h10;
  localparam logic [4:0] MAX_SEL_SINGLE = 5'h10;
  localparam logic [4:0] MAX_SEL_DUAL = 5'h15;
  localparam logic [4:0] FAST_MAX_SINGLE = 5'h04;
  localparam logic [4:0] FAST_MAX_DUAL = 5'h07;
  localparam logic [3:0] BAUD_CODE_MAX = 4'hD;
  // Characters.
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] DELIM_MIN = 8'h20;
  localparam logic [7:0] DELIM_MAX = 8'h7D;
  localparam logic [7:0] CHAR_MINUS = 8'h2D;
  // Clock and baud divider.
  localparam int CLK_HZ = 20_000_000;
  localparam int OVERSAMPLE = 16;

  typedef enum logic [1:0] {
    DUMP_DEC,
    DUMP_BIN,
    DUMP_TAB,
    DUMP_BAD
  } cbdf_kind_t;

  // Oversampling divider for a rate code; rates are held in tenths of a baud.
  function automatic logic [15:0] baud_div(input logic [3:0] code);
    int b10;
    case (code)
      4'h0: b10 = 750;
      4'h1: b10 = 1100;
      4'h2: b10 = 1345;
      4'h3: b10 = 1500;
      4'h4: b10 = 3000;
      4'h5: b10 = 6000;
      4'h6: b10 = 12000;
      4'h7: b10 = 18000;
      4'h8: b10 = 20000;
      4'h9: b10 = 24000;
      4'hA: b10 = 48000;
      4'hB: b10 = 96000;
      4'hC: b10 = 192000;
      default: b10 = 384000;
    endcase
    baud_div = 16'((CLK_HZ * 10) / (OVERSAMPLE * b10));
  endfunction

  // Number of the lowest set bit of a curve mask, zero when empty.
  function automatic logic [4:0] first_one(input logic [MASK_W-1:0] m);
    first_one = 5'h00;
    for (int i = MASK_W - 1; i >= 0; i--) begin
      if (m[i]) begin
        first_one = 5'(i);
      end
    end
  endfunction
endpackage

// ---- hw/cbdf_dec_fmt.sv ----
`timescale 1ns/100ps
module cbdf_dec_fmt (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [31:0] value,
  input wire logic ch_ready,
  output logic [7:0] ch,
  output logic ch_valid,
  output logic ch_last
);
  import cbdf_pkg::*;

  typedef enum logic [1:0] {F_IDLE, F_DIV, F_SIGN, F_OUT} cbdf_fmt_t;

  cbdf_fmt_t state_reg;
  logic [31:0] num_reg;
  logic [3:0] rem_reg;
  logic [4:0] bit_cnt_reg;
  logic neg_reg;
  logic [3:0] dig_reg [DIGITS];
  logic [3:0] depth_reg;
  logic [4:0] trial;
  logic [4:0] sub;
  logic ge;
  logic [3:0] digit;
  logic [31:0] quot;

  // One restoring step of division by ten per cycle.
  assign trial = {rem_reg, num_reg[31]};
  assign sub = trial - 5'h0A;
  assign ge = trial >= 5'h0A;
  assign digit = ge ? sub[3:0] : trial[3:0];
  assign quot = {num_reg[30:0], ge};

  // Digits are produced least significant first and sent from the top.
  always_comb begin
    ch = {4'h3, dig_reg[depth_reg - 4'h1]};
    ch_valid = 1'b0;
    ch_last = 1'b0;
    case (state_reg)
      F_SIGN: begin
        ch = CHAR_MINUS;
        ch_valid = neg_reg;
      end
      F_OUT: begin
        ch_valid = 1'b1;
        ch_last = depth_reg == 4'h1;
      end
      default: ch_valid = 1'b0;
    endcase
  end

  // Thirty-two cycles per digit keeps the divider to a few gates.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= F_IDLE;
      num_reg <= 32'h0;
      rem_reg <= 4'h0;
      bit_cnt_reg <= 5'h00;
      neg_reg <= 1'b0;
      depth_reg <= 4'h0;
      for (int i = 0; i < DIGITS; i++) begin
        dig_reg[i] <= 4'h0;
      end
    end else begin
      case (state_reg)
        F_IDLE: begin
          if (start) begin
            neg_reg <= value[31];
            num_reg <= value[31] ? 32'h0 - value : value;
            rem_reg <= 4'h0;
            bit_cnt_reg <= 5'h00;
            depth_reg <= 4'h0;
            state_reg <= F_DIV;
          end
        end
        F_DIV: begin
          num_reg <= quot;
          rem_reg <= digit;
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          if (bit_cnt_reg == 5'h1F) begin
            dig_reg[depth_reg] <= digit;
            depth_reg <= depth_reg + 4'h1;
            rem_reg <= 4'h0;
            if (quot == 32'h0) begin
              state_reg <= F_SIGN;
            end
          end
        end
        F_SIGN: begin
          if (!neg_reg || ch_ready) begin
            state_reg <= F_OUT;
          end
        end
        F_OUT: begin
          if (ch_ready) begin
            depth_reg <= depth_reg - 4'h1;
            if (depth_reg == 4'h1) begin
              state_reg <= F_IDLE;
            end
          end
        end
        default: begin
          state_reg <= F_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- hw/cbdf_top.sv ----
// Function
// (R01) Binary point: two bytes MSB first; low frequency half unsigned.
// (R02) Binary dump sends exactly twice the curve length in data bytes.
// (R03) Binary dump puts no terminator between bytes, one terminator at end.
// (R04) Binary dump carries raw fixed-point values, never floating point.
// (R05) Standard selector is a stored curve number, 0..16 single, 0..21 dual.
// (R06) Frequency spans curves 15 (low) and 16 (high); binary sends each.
// (R07) Host rebuilds frequency as 65536 times upper plus unsigned lower.
// (R08) Host accepts very large binary blocks without loss.
// (R09) Binary dump needs eight-bit serial character frames at both ends.
// (R10) Fast mode binary: one curve, two bytes per point, MSB first.
// (R11) Fast selector codes 0..4 always, 5..7 only in dual modes.
// (R12) Tabular dump only in standard mode, refused in fast mode.
// (R13) Tabular mask nonzero, 17 bits single or 22 bits dual.
// (R14) Each set mask bit picks one curve; clear bits skip curves.
// (R15) Tabular row: values ascending, delimiter between, terminator after.
// (R16) Decimal and tabular dumps join both frequency halves into one value.
// (R17) Tabular dump writes fixed-point decimal text for every curve.
// (R18) Rate code 0..13 selects 75 up to 38400 baud.
// (R19) Option bits: eight data bits, parity, odd parity, echo, prompt.
// (R20) Delimiter accepts 13 or 32..125, sent between numeric values.
// (R21) Host keeps reading decimal responses until the whole curve arrives.
// (R22) Store mask bit number equals the curve's dump selector.
// (R23) Dump of a curve not stored is refused with parameter error, no data.
`timescale 1ns/100ps
module cbdf_top #(
  parameter int PT_W = 17,
  parameter logic [7:0] TERM_CHAR = cbdf_pkg::CHAR_CR
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic CURVE_RD,
  output logic CURVE_FAST,
  output logic [4:0] CURVE_SEL,
  output logic [PT_W-1:0] CURVE_ADDR,
  input wire logic [15:0] CURVE_RDATA,
  output logic [3:0] SER_BAUD_CODE,
  output logic [15:0] SER_BAUD_DIV,
  output logic [4:0] SER_OPTS,
  output logic [7:0] DELIM_CHAR,
  output logic BUSY
);
  import cbdf_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_FETCH, S_WAIT, S_TAKE, S_HI, S_LO, S_FMT, S_SEP, S_TERM, S_STEP
  } cbdf_state_t;

  // Write and read sides of the register bus.
  logic aw_held_reg, w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write;
  logic addr_ok_w, addr_ok_r;
  logic [31:0] rd_mux;
  // Configuration and status.
  logic fast_cfg_reg, dual_cfg_reg;
  logic [MASK_W-1:0] store_mask_reg;
  logic [PT_W-1:0] len_reg;
  logic err_reg, done_reg;
  logic go_reg;
  cbdf_kind_t go_kind_reg;
  logic [MASK_W-1:0] go_arg_reg;
  // Command check.
  cbdf_kind_t cmd_kind;
  logic [MASK_W-1:0] cmd_arg, tab_mask;
  logic [4:0] cmd_sel, max_sel;
  logic cmd_ok;
  logic wr_err;
  // Dump engine.
  cbdf_state_t state_reg;
  cbdf_kind_t kind_reg;
  logic [4:0] sel_reg;
  logic [MASK_W-1:0] grp_mask_reg, rem_reg, rem_clr;
  logic [PT_W-1:0] point_reg;
  logic lo_phase_reg;
  logic [15:0] lo_reg;
  logic [31:0] value_reg;
  logic fmt_start_reg;
  logic end_pulse_reg;
  logic can_tx;
  logic is_freq;
  logic last_pt;
  logic [7:0] fmt_ch;
  logic fmt_valid, fmt_last, fmt_ready;

  // Byte-lane merge of a write into the old register contents.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= REG_STATUS) && (a[1:0] == 2'b00);
  endfunction

  assign do_write = aw_held_reg && w_held_reg && !S_AXI_BVALID;
  assign addr_ok_w = mapped(aw_addr_reg);
  assign addr_ok_r = mapped(S_AXI_ARADDR);

  // Address and data are taken independently and joined before the answer.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      aw_addr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'b00;
    end else begin
      if (S_AXI_AWREADY && S_AXI_AWVALID) begin
        aw_addr_reg <= S_AXI_AWADDR;
        aw_held_reg <= 1'b1;
        S_AXI_AWREADY <= 1'b0;
      end else if (!aw_held_reg) begin
        S_AXI_AWREADY <= 1'b1;
      end
      if (S_AXI_WREADY && S_AXI_WVALID) begin
        wdata_reg <= S_AXI_WDATA;
        wstrb_reg <= S_AXI_WSTRB;
        w_held_reg <= 1'b1;
        S_AXI_WREADY <= 1'b0;
      end else if (!w_held_reg) begin
        S_AXI_WREADY <= 1'b1;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= addr_ok_w ? 2'b00 : 2'b10;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Read data mux; unmapped words read zero with a slave error.
  always_comb begin
    rd_mux = 32'h0;
    case (S_AXI_ARADDR)
      REG_CTRL: begin
        rd_mux[CTRL_FAST_BIT] = fast_cfg_reg;
        rd_mux[CTRL_DUAL_BIT] = dual_cfg_reg;
      end
      REG_STORE_MASK: rd_mux[MASK_W-1:0] = store_mask_reg;
      REG_LENGTH: rd_mux[PT_W-1:0] = len_reg;
      REG_SERIAL: rd_mux = {19'h0, SER_OPTS, 4'h0, SER_BAUD_CODE};
      REG_DELIM: rd_mux[7:0] = DELIM_CHAR;
      REG_STATUS: begin
        rd_mux[STAT_BUSY_BIT] = BUSY;
        rd_mux[STAT_ERR_BIT] = err_reg;
        rd_mux[STAT_DONE_BIT] = done_reg;
      end
      default: rd_mux = 32'h0;
    endcase
  end

  // One read is answered in the cycle after its address is taken.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= 2'b00;
    end else begin
      if (S_AXI_ARREADY && S_AXI_ARVALID) begin
        S_AXI_RDATA <= rd_mux;
        S_AXI_RRESP <= addr_ok_r ? 2'b00 : 2'b10;
        S_AXI_RVALID <= 1'b1;
        S_AXI_ARREADY <= 1'b0;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end else if (!S_AXI_RVALID) begin
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // Command check; any refused dump sends nothing at all.
  always_comb begin
    cmd_kind = cbdf_kind_t'(wdata_reg[CMD_KIND_LSB +: 2]);
    cmd_arg = wdata_reg[MASK_W-1:0];
    cmd_sel = cmd_arg[4:0];
    tab_mask = cmd_arg;
    tab_mask[FREQ_HI_CURVE] = 1'b0;
    max_sel = dual_cfg_reg ? MAX_SEL_DUAL : MAX_SEL_SINGLE; // (R05)
    cmd_ok = 1'b0;
    if (fast_cfg_reg) begin
      cmd_ok = (cmd_kind != DUMP_TAB) && (cmd_kind != DUMP_BAD) &&
               (cmd_arg[MASK_W-1:5] == 17'h0) &&
               (cmd_sel <= (dual_cfg_reg ? FAST_MAX_DUAL
                                         : FAST_MAX_SINGLE)); // (R11) (R12)
    end else if (cmd_kind == DUMP_TAB) begin
      cmd_ok = (tab_mask != 22'h0) &&
               (dual_cfg_reg || cmd_arg[MASK_W-1:17] == 5'h00) &&
               ((tab_mask & ~store_mask_reg) == 22'h0); // (R13) (R23)
    end else if (cmd_kind != DUMP_BAD) begin
      cmd_ok = (cmd_arg[MASK_W-1:5] == 17'h0) && (cmd_sel <= max_sel) &&
               store_mask_reg[cmd_sel]; // (R22) (R23)
    end
    if (cmd_kind == DUMP_BIN && !SER_OPTS[OPT_DATA8_BIT]) begin
      cmd_ok = 1'b0; // (R09)
    end
    if (len_reg == '0 || BUSY || go_reg) begin
      cmd_ok = 1'b0;
    end
    wr_err = 1'b0;
    if (do_write) begin
      case (aw_addr_reg)
        REG_CMD: wr_err = !cmd_ok;
        REG_SERIAL: wr_err = wstrb_reg[0] &&
                             wdata_reg[3:0] > BAUD_CODE_MAX;
        REG_DELIM: wr_err = wstrb_reg[0] && !(wdata_reg[7:0] == CHAR_CR ||
                             (wdata_reg[7:0] >= DELIM_MIN &&
                              wdata_reg[7:0] <= DELIM_MAX));
        default: wr_err = 1'b0;
      endcase
    end
  end

  // Software-written settings steer the dump engine and the serial port.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fast_cfg_reg <= 1'b0;
      dual_cfg_reg <= 1'b0;
      store_mask_reg <= '0;
      len_reg <= PT_W'(LEN_RST);
      SER_BAUD_CODE <= SER_BAUD_RST;
      SER_BAUD_DIV <= baud_div(SER_BAUD_RST);
      SER_OPTS <= SER_OPT_RST;
      DELIM_CHAR <= DELIM_RST;
      go_reg <= 1'b0;
      go_kind_reg <= DUMP_DEC;
      go_arg_reg <= '0;
    end else begin
      go_reg <= 1'b0;
      if (do_write && !wr_err) begin
        case (aw_addr_reg)
          REG_CTRL: begin
            if (wstrb_reg[0]) begin
              fast_cfg_reg <= wdata_reg[CTRL_FAST_BIT];
              dual_cfg_reg <= wdata_reg[CTRL_DUAL_BIT];
            end
          end
          REG_STORE_MASK: store_mask_reg <= MASK_W'(merge(
              32'(store_mask_reg), wdata_reg, wstrb_reg));
          REG_LENGTH: len_reg <= PT_W'(merge(32'(len_reg), wdata_reg,
                                             wstrb_reg));
          REG_SERIAL: begin
            if (wstrb_reg[0]) begin
              SER_BAUD_CODE <= wdata_reg[3:0]; // (R18)
              SER_BAUD_DIV <= baud_div(wdata_reg[3:0]); // (R18)
            end
            if (wstrb_reg[1]) SER_OPTS <= wdata_reg[SER_OPT_LSB +: 5]; // (R19)
          end
          REG_DELIM: if (wstrb_reg[0]) DELIM_CHAR <= wdata_reg[7:0]; // (R20)
          REG_CMD: begin
            go_reg <= 1'b1;
            go_kind_reg <= cmd_kind;
            go_arg_reg <= cmd_arg;
          end
          default: go_reg <= 1'b0;
        endcase
      end
    end
  end

  // Sticky flags; a new event in the clearing cycle survives the clear.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      err_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      if (wr_err) begin
        err_reg <= 1'b1; // (R23)
      end else if (do_write && aw_addr_reg == REG_STATUS && wstrb_reg[0] &&
                   wdata_reg[STAT_ERR_BIT]) begin
        err_reg <= 1'b0;
      end
      if (end_pulse_reg) begin
        done_reg <= 1'b1;
      end else if (do_write && aw_addr_reg == REG_STATUS && wstrb_reg[0] &&
                   wdata_reg[STAT_DONE_BIT]) begin
        done_reg <= 1'b0;
      end
    end
  end

  assign can_tx = !TX_VALID || TX_READY;
  assign fmt_ready = (state_reg == S_FMT) && can_tx;
  assign is_freq = (sel_reg == FREQ_LO_CURVE || sel_reg == FREQ_HI_CURVE) &&
                   kind_reg != DUMP_BIN && !CURVE_FAST;
  assign last_pt = point_reg == len_reg - PT_W'(1);
  assign rem_clr = rem_reg & ~(MASK_W'(1) << sel_reg);

  cbdf_dec_fmt u_fmt (
    .clk(CLK),
    .reset_n(RESET_N),
    .start(fmt_start_reg),
    .value(value_reg),
    .ch_ready(fmt_ready),
    .ch(fmt_ch),
    .ch_valid(fmt_valid),
    .ch_last(fmt_last)
  );

  // Dump engine: fetch a point, then send it as bytes or decimal text.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= S_IDLE;
      kind_reg <= DUMP_DEC;
      sel_reg <= 5'h00;
      grp_mask_reg <= '0;
      rem_reg <= '0;
      point_reg <= '0;
      lo_phase_reg <= 1'b0;
      lo_reg <= 16'h0;
      value_reg <= 32'h0;
      fmt_start_reg <= 1'b0;
      end_pulse_reg <= 1'b0;
      TX_DATA <= 8'h00;
      TX_VALID <= 1'b0;
      CURVE_RD <= 1'b0;
      CURVE_FAST <= 1'b0;
      CURVE_SEL <= 5'h00;
      CURVE_ADDR <= '0;
      BUSY <= 1'b0;
    end else begin
      CURVE_RD <= 1'b0;
      fmt_start_reg <= 1'b0;
      end_pulse_reg <= 1'b0;
      if (TX_READY) begin
        TX_VALID <= 1'b0;
      end
      case (state_reg)
        S_IDLE: begin
          if (go_reg) begin
            BUSY <= 1'b1;
            kind_reg <= go_kind_reg;
            CURVE_FAST <= fast_cfg_reg;
            point_reg <= '0;
            grp_mask_reg <= go_arg_reg & ~(MASK_W'(1) << FREQ_HI_CURVE);
            rem_reg <= go_arg_reg & ~(MASK_W'(1) << FREQ_HI_CURVE);
            sel_reg <= (go_kind_reg == DUMP_TAB) ?
                       first_one(go_arg_reg) : go_arg_reg[4:0]; // (R14)
            state_reg <= S_FETCH;
          end
        end
        S_FETCH: begin
          CURVE_RD <= 1'b1;
          CURVE_ADDR <= point_reg;
          CURVE_SEL <= is_freq ? FREQ_LO_CURVE : sel_reg; // (R06)
          lo_phase_reg <= is_freq; // (R16)
          state_reg <= S_WAIT;
        end
        S_WAIT: state_reg <= S_TAKE;
        S_TAKE: begin
          if (lo_phase_reg) begin
            lo_reg <= CURVE_RDATA;
            lo_phase_reg <= 1'b0;
            CURVE_RD <= 1'b1;
            CURVE_SEL <= FREQ_HI_CURVE;
            state_reg <= S_WAIT;
          end else begin
            value_reg <= is_freq ? {CURVE_RDATA, lo_reg}
                   : {{16{CURVE_RDATA[15]}}, CURVE_RDATA}; // (R16)
            if (kind_reg == DUMP_BIN) begin
              state_reg <= S_HI; // (R04)
            end else begin
              fmt_start_reg <= 1'b1; // (R17)
              state_reg <= S_FMT;
            end
          end
        end
        S_HI: begin
          if (can_tx) begin
            TX_DATA <= value_reg[15:8]; // (R01) (R10)
            TX_VALID <= 1'b1;
            state_reg <= S_LO;
          end
        end
        S_LO: begin
          if (can_tx) begin
            TX_DATA <= value_reg[7:0]; // (R02)
            TX_VALID <= 1'b1;
            state_reg <= S_STEP; // (R03)
          end
        end
        S_FMT: begin
          if (fmt_valid && can_tx) begin
            TX_DATA <= fmt_ch;
            TX_VALID <= 1'b1;
            if (fmt_last) begin
              rem_reg <= rem_clr;
              sel_reg <= (kind_reg == DUMP_TAB) ? first_one(rem_clr)
                                                : sel_reg;
              state_reg <= (kind_reg == DUMP_TAB && rem_clr != '0) ?
                           S_SEP : S_TERM; // (R15)
            end
          end
        end
        S_SEP: begin
          if (can_tx) begin
            TX_DATA <= DELIM_CHAR; // (R15) (R20)
            TX_VALID <= 1'b1;
            state_reg <= S_FETCH;
          end
        end
        S_TERM: begin
          if (can_tx) begin
            TX_DATA <= TERM_CHAR;
            TX_VALID <= 1'b1;
            if (kind_reg == DUMP_BIN) begin
              BUSY <= 1'b0; // (R03)
              end_pulse_reg <= 1'b1;
              state_reg <= S_IDLE;
            end else begin
              state_reg <= S_STEP;
            end
          end
        end
        S_STEP: begin
          if (!last_pt) begin
            point_reg <= point_reg + PT_W'(1);
            rem_reg <= grp_mask_reg;
            sel_reg <= (kind_reg == DUMP_TAB) ? first_one(grp_mask_reg)
                                              : sel_reg;
            state_reg <= S_FETCH;
          end else if (kind_reg == DUMP_BIN) begin
            state_reg <= S_TERM; // (R02) (R03)
          end else begin
            BUSY <= 1'b0;
            end_pulse_reg <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// ---- sim/cbdf_top_props.sv ----
`timescale 1ns/100ps
module cbdf_top_props (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic CURVE_RD,
  input wire logic CURVE_FAST,
  input wire logic [4:0] CURVE_SEL,
  input wire logic [3:0] SER_BAUD_CODE,
  input wire logic [7:0] DELIM_CHAR,
  input wire logic BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // Answers and bytes stay put until the other side takes them.
  a_bresp_hold: assert property(S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped early");
  a_rresp_hold: assert property(S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
    else $error("read response dropped early");
  a_byte_hold: assert property (TX_VALID && !TX_READY |=>
    TX_VALID && $stable(TX_DATA)) else $error("byte changed before taken");
  a_term_last: assert property (TX_VALID && !BUSY |->
    TX_DATA == 8'h0D) else $error("only the terminator may trail");
  a_read_pulse: assert property (CURVE_RD |-> BUSY ##1 !CURVE_RD)
    else $error("curve read not a lone pulse in a dump");
  a_std_sel: assert property (CURVE_RD && !CURVE_FAST |->
    CURVE_SEL <= 5'h15) else $error("standard selector out of range");
  a_fast_sel: assert property (CURVE_RD && CURVE_FAST |->
    CURVE_SEL <= 5'h07) else $error("fast selector out of range");
  a_baud_code: assert property (SER_BAUD_CODE <= 4'hD)
    else $error("rate code beyond table");
  a_delim_ok: assert property (DELIM_CHAR == 8'h0D ||
    (DELIM_CHAR >= 8'h20 && DELIM_CHAR <= 8'h7D)) else $error("bad delimiter");
endmodule
bind cbdf_top cbdf_top_props i_props (.CLK, .RESET_N, .S_AXI_BVALID,
  .S_AXI_BREADY, .S_AXI_RVALID, .S_AXI_RREADY, .TX_DATA, .TX_VALID,
  .TX_READY, .CURVE_RD, .CURVE_FAST, .CURVE_SEL, .SER_BAUD_CODE,
  .DELIM_CHAR, .BUSY);

// ---- sim/cbdf_host_model.sv ----
`timescale 1ns/100ps
module cbdf_host_model (
  input wire logic clk,
  input wire logic rd,
  input wire logic [4:0] sel,
  input wire logic fast,
  input wire logic [16:0] addr,
  output logic [15:0] rdata,
  output logic tx_ready
);
  logic [15:0] data_reg = 16'h0000;
  logic [1:0] hold_reg = 2'h0;
  logic [1:0] ph_reg = 2'h0;
  // A word stays valid two cycles, then inverts so a late sample shows.
  always_ff @(posedge clk) begin
    ph_reg <= (ph_reg == 2'h2) ? 2'h0 : ph_reg + 2'h1;
    if (rd) begin
      data_reg <= {sel, 1'b1, fast, 1'b1, addr[7:0]};
      hold_reg <= 2'h2;
    end else if (hold_reg != 2'h0) begin
      hold_reg <= hold_reg - 2'h1;
    end
  end
  assign rdata = (hold_reg != 2'h0) ? data_reg : ~data_reg;
  // The host stalls one cycle in three but keeps reading to the end.
  assign tx_ready = ph_reg != 2'h0;
endmodule

// ---- sim/cbdf_top_tb.sv ----
`timescale 1ns/100ps
module cbdf_top_tb;
  import cbdf_pkg::*;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0;
  logic rready = 0, awr, wrd, arr, bv, rv, txv, txr, crd, cf, busy;
  logic [1:0] bresp, rresp, dresp;
  logic [7:0] awa = 0, ara = 0, txd, dlm;
  logic [31:0] wd = 0, rdt, d;
  logic [4:0] cs, opts;
  logic [16:0] ca;
  logic [15:0] crw, bdiv;
  logic [3:0] bcode;
  logic [7:0] q[$];
  int errors = 0, checks_done = 0;
  cbdf_top i_cbdf_top (.CLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdt), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rready), .TX_DATA(txd), .TX_VALID(txv), .TX_READY(txr),
    .CURVE_RD(crd), .CURVE_FAST(cf), .CURVE_SEL(cs), .CURVE_ADDR(ca),
    .CURVE_RDATA(crw), .SER_BAUD_CODE(bcode), .SER_BAUD_DIV(bdiv),
    .SER_OPTS(opts), .DELIM_CHAR(dlm), .BUSY(busy));
  cbdf_host_model i_cbdf_host_model (.clk(clk), .rd(crd), .sel(cs), .fast(cf),
    .addr(ca), .rdata(crw), .tx_ready(txr));
  // Clock, and a log of every byte the host accepts.
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (txv && txr) q.push_back(txd);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Both write channels go out together; the extra edge keeps drives apart.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awa <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (!bv);
    dresp = bresp;
    bready <= 0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    ara <= a;
    arv <= 1;
    rready <= 1;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
    end while (!rv);
    rready <= 0;
    d = rdt;
    dresp = rresp;
    @(posedge clk);
  endtask
  task automatic t_regs;
    rd_reg(REG_SERIAL);
    chk(d, 32'h0000010B);
    rd_reg(8'h1C);
    chk(dresp, 2'b10);
    wr(8'h1C, 32'h0);
    chk(dresp, 2'b10);
    wr(REG_SERIAL, 32'h1F0D);
    wr(REG_SERIAL, 32'h1F0E);
    chk({bcode, bdiv, 3'h0, opts}, {4'hD, 16'h0020, 8'h1F});
    wr(REG_DELIM, 32'h7E);
    chk(dlm, 8'h2C);
    wr(REG_DELIM, 32'h0D);
    chk(dlm, 8'h0D);
    wr(REG_DELIM, 32'h7D);
  endtask
  task automatic t_bin(input logic f, input logic [4:0] sel, input int n);
    wr(REG_CTRL, {31'h0, f});
    wr(REG_LENGTH, n);
    q.delete();
    wr(REG_CMD, {8'h01, 19'h0, sel});
    for (int i = 0; i < 3000 && q.size() < 2 * n + 1; i++) @(posedge clk);
    chk(q.size(), 2 * n + 1);
    for (int p = 0; p < 2 * n; p++) begin
      chk(q[p], p[0] ? p[8:1] : {sel, 1'b1, f, 1'b1});
    end
    chk(q[2 * n], 8'h0D);
    rd_reg(REG_STATUS);
    chk({d[2], d[0]}, 2'b10);
  endtask
  task automatic t_refuse;
    logic [7:0] sa [6] = '{0, 0, 0, 0, 0, REG_SERIAL};
    logic [31:0] sv [6] = '{0, 1, 1, 0, 0, 32'hB};
    logic [31:0] cv [6] = '{32'h01000001, 32'h02000001, 32'h01000005,
      32'h02020000, 32'h01000011, 32'h01000000};
    for (int k = 0; k < 6; k++) begin
      wr(sa[k], sv[k]);
      wr(REG_STATUS, 32'h6);
      q.delete();
      wr(REG_CMD, cv[k]);
      repeat (30) @(posedge clk);
      rd_reg(REG_STATUS);
      chk(q.size(), 0);
      chk(d[1], 1);
    end
  endtask
  task automatic t_text(input logic [31:0] c, input int n, input string s);
    wr(REG_LENGTH, n);
    q.delete();
    wr(REG_CMD, c);
    for (int i = 0; i < 6000 && q.size() < s.len(); i++) @(posedge clk);
    chk(q.size(), s.len());
    foreach (q[i]) chk(q[i], s[i]);
  endtask
  task automatic stop_test;
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #1000000;
    errors++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    t_regs;
    wr(REG_STORE_MASK, 32'h8005);
    t_bin(0, 5'd2, 3);
    t_bin(0, 5'd15, 2);
    t_bin(1, 5'd4, 2);
    t_refuse;
    t_text(32'h02008005, 1, $sformatf("%0d%c%0d%c%0d%c", 1280, 8'h7D, 5376,
      8'h7D, $signed(32'h85007D00), 8'h0D));
    t_text(32'h00000002, 2, $sformatf("%0d%c%0d%c", 5376, 8'h0D, 5377,
      8'h0D));
    stop_test;
  end
endmodule
